// >>> flash_host_pkg.sv
/*
 * Constants, command codes, bus timings and carrier structs for the host-side
 * controller of an asynchronous parallel NOR flash.
 * Assumes a 100 MHz system clock; all flash timings are converted to cycles.
 */
// Summary of operation
// R1 - Verify read returns 00h unprotected, 01h protected
// R2 - Host puts sector on sector_select_bits
// R3 - Read: chip select, output enable low, write high
// R4 - Flash starts in read-array after power or reset
// R5 - Read-array persists until command register changes
// R6 - Write: write enable, chip select low, output high
// R7 - Unlock bypass programs with two writes
// R8 - Bad command sequence returns to read-array
// R9 - Identification command enables code reads on low byte
// R10 - Output enable high tristates flash outputs
// R11 - Reset low aborts, tristates, ignores, returns read-array
// R12 - Ready-busy low until reset recovery completes
// R13 - Host waits recovery time before first read
// R14 - Host reissues operation interrupted by reset
// R15 - F0h aborts failed operation, then valid command
// R16 - Address 00 manufacturer, 01 device code
// R17 - Codes also readable via high id voltage
// R18 - Id command: AAh@555, 55h@2AA, 90h@555 (word)
// R19 - F0h anywhere resets, even mid-sequence
// R20 - Identification mode holds until reset command
// R21 - Chip select high ignores bus cycles
// R22 - Write latched on first rising control edge
package flash_host_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    // Flash bus timings in ns (plain defaults, tune to the speed grade)
    localparam int ACCESS_NS = 70;
    localparam int WRITE_PULSE_NS = 35;
    localparam int MIN_CLEAR_PULSE_TIME_NS = 500;
    localparam int CLEAR_HIGH_TO_READ_TIME_NS = 50;
    localparam int READY_RECOVERY_NS = 20000;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_CYC = (MIN_CLEAR_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RH_CYC = (CLEAR_HIGH_TO_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_CYC = (READY_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    // Command sequence words (word mode)
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 19'h0_0555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 19'h0_02AA;
    localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 19'h0_0000;
    localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 19'h0_0001;
    localparam logic [ADDR_W-1:0] PROT_VERIFY_ADDR = 19'h0_0002;
    localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
    localparam logic [DATA_W-1:0] ID_CMD = 16'h0090;
    localparam logic [DATA_W-1:0] RESET_CMD = 16'h00F0;
    localparam logic [DATA_W-1:0] PROTECTED_CODE = 16'h0001;
    localparam int SECTOR_LSB = 12;
    localparam int SECTOR_W = 7;

    typedef enum logic [2:0]
    {
        OP_READ,
        OP_WRITE,
        OP_RESET_CMD,
        OP_ID_READ,
        OP_PROT_VERIFY,
        OP_HW_CLEAR
    } op_t;

    typedef struct packed
    {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_t;

    typedef struct packed
    {
        logic              chip_sel_n;
        logic              out_en_n;
        logic              write_en_n;
        logic              clear_n;
        logic [ADDR_W-1:0] addr;
    } pins_t;
endpackage

// >>> flash_host_ctrl.sv
/*
 * Host controller driving an asynchronous NOR flash over its parallel pins.
 * Assumes flash outputs are synchronous to ref_clk; one request at a time.
 */
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl
(
    input  wire logic                         ref_clk,
    input  wire logic                         resetn,
    input  wire logic                         clk_en,
    input  wire logic                         req_valid,
    output logic                              req_ready,
    input  wire flash_host_pkg::req_t         req,
    output logic                              rsp_valid,
    output logic [flash_host_pkg::DATA_W-1:0] rsp_data,
    output logic                              rsp_protected,
    output flash_host_pkg::pins_t             pins,
    output logic [flash_host_pkg::DATA_W-1:0] data_out,
    output logic                              data_oe,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_in,
    input  wire logic                         ready_busy_out
);
    import flash_host_pkg::*;

    typedef enum logic [3:0]
    {
        S_IDLE,
        S_WR_LOW,
        S_WR_HIGH,
        S_RD,
        S_CLR_LOW,
        S_CLR_WAIT_RDY,
        S_CLR_RH
    } state_t;

    state_t            state_q, state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [2:0]        step_q;
    logic [2:0]        nsteps_q;
    req_t              cur_q;
    pins_t             pins_q;
    logic [DATA_W-1:0] dout_q;
    logic              oe_q;
    logic              rsp_valid_q;
    logic [DATA_W-1:0] rsp_data_q;
    logic              prot_q;

    // One write of a command script: address/data by step index
    function automatic logic [ADDR_W+DATA_W-1:0] script(input op_t op, input logic [2:0] s,
                                                        input req_t r);
        logic [ADDR_W+DATA_W-1:0] w;
        w = {r.addr, r.data};
        if (op == OP_RESET_CMD)
            w = {r.addr, RESET_CMD}; // R15 R19
        else if (op != OP_WRITE)
            case (s)
                3'd0:    w = {UNLOCK_ADDR1, UNLOCK_DATA1}; // R18
                3'd1:    w = {UNLOCK_ADDR2, UNLOCK_DATA2}; // R18
                default: w = {UNLOCK_ADDR1, ID_CMD};       // R18
            endcase
        return w;
    endfunction

    wire logic              timer_done = (cnt_q == '0);
    wire logic [ADDR_W+DATA_W-1:0] step_word = script(cur_q.op, step_q, cur_q);
    wire logic [ADDR_W-1:0] step_addr  = step_word[ADDR_W+DATA_W-1:DATA_W];
    wire logic [DATA_W-1:0] step_data  = step_word[DATA_W-1:0];
    wire logic              needs_id   = (req.op == OP_ID_READ) || (req.op == OP_PROT_VERIFY);
    // Verify address puts the sector on the upper lines
    wire logic [ADDR_W-1:0] rd_addr    =
        (cur_q.op == OP_PROT_VERIFY) ? {cur_q.addr[SECTOR_LSB+SECTOR_W-1:SECTOR_LSB],
                                        PROT_VERIFY_ADDR[SECTOR_LSB-1:0]} // R2
        : (cur_q.op == OP_ID_READ) ? (cur_q.addr[0] ? ID_DEV_ADDR : ID_MFR_ADDR) // R16
        : cur_q.addr;
    wire logic              last_step  = (step_q + 3'd1 >= nsteps_q);

    assign req_ready     = (state_q == S_IDLE);
    assign rsp_valid     = rsp_valid_q;
    assign rsp_data      = rsp_data_q;
    assign rsp_protected = prot_q;
    assign pins          = pins_q;
    assign data_out      = dout_q;
    assign data_oe       = oe_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (req_valid)
                    state_d = (req.op == OP_HW_CLEAR) ? S_CLR_LOW
                            : (req.op == OP_READ) ? S_RD : S_WR_LOW;
            // Entry cycle drives address and data and lowers the strobe; the pulse count runs from there
            S_WR_LOW:       if (timer_done && !pins_q.write_en_n) state_d = S_WR_HIGH;
            S_WR_HIGH:
                if (timer_done)
                    state_d = !last_step ? S_WR_LOW
                            : (cur_q.op == OP_ID_READ || cur_q.op == OP_PROT_VERIFY) ? S_RD
                            : S_IDLE;
            S_RD:           if (timer_done) state_d = S_IDLE;
            S_CLR_LOW:      if (timer_done) state_d = S_CLR_WAIT_RDY;
            S_CLR_WAIT_RDY: if (ready_busy_out || timer_done) state_d = S_CLR_RH;
            S_CLR_RH:       if (timer_done) state_d = S_IDLE;
            default:        state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state_q     <= S_IDLE;
            cnt_q       <= '0;
            step_q      <= '0;
            nsteps_q    <= '0;
            cur_q       <= '0;
            pins_q      <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1,
                             clear_n: 1'b1, addr: '0};
            dout_q      <= '0;
            oe_q        <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= '0;
            prot_q      <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q     <= state_d;
            rsp_valid_q <= 1'b0;
            if (!timer_done)
                cnt_q <= cnt_q - 1'b1;
            case (state_q)
                S_IDLE:
                    if (req_valid)
                    begin
                        cur_q    <= req;
                        step_q   <= '0;
                        nsteps_q <= needs_id ? 3'd3 : 3'd1;
                        if (req.op == OP_HW_CLEAR)
                        begin
                            cnt_q          <= CNT_W'(CLEAR_CYC);
                            pins_q.clear_n <= 1'b0; // R11
                        end
                        else if (req.op == OP_READ)
                        begin
                            cnt_q             <= CNT_W'(ACCESS_CYC);
                            pins_q.addr       <= req.addr;
                            pins_q.chip_sel_n <= 1'b0; // R3
                            pins_q.out_en_n   <= 1'b0; // R3
                        end
                        else
                            cnt_q <= '0;
                    end
                S_WR_LOW:
                    if (state_d == S_WR_HIGH)
                    begin
                        // Address and data are set up one pulse before the edge
                        pins_q.write_en_n <= 1'b1; // R22
                        pins_q.chip_sel_n <= 1'b1;
                        cnt_q             <= CNT_W'(WRITE_CYC);
                    end
                    else if (pins_q.write_en_n)
                    begin
                        pins_q.addr       <= step_addr;
                        dout_q            <= step_data;
                        oe_q              <= 1'b1;
                        pins_q.out_en_n   <= 1'b1; // R6
                        pins_q.chip_sel_n <= 1'b0; // R6
                        pins_q.write_en_n <= 1'b0; // R6
                        cnt_q             <= CNT_W'(WRITE_CYC);
                    end
                S_WR_HIGH:
                    if (timer_done)
                    begin
                        oe_q   <= 1'b0;
                        step_q <= step_q + 3'd1;
                        if (state_d == S_RD)
                        begin
                            pins_q.addr       <= rd_addr;
                            pins_q.chip_sel_n <= 1'b0; // R9
                            pins_q.out_en_n   <= 1'b0;
                            cnt_q             <= CNT_W'(ACCESS_CYC);
                        end
                        else if (state_d == S_IDLE)
                            rsp_valid_q <= 1'b1;
                    end
                S_RD:
                    if (timer_done)
                    begin
                        pins_q.chip_sel_n <= 1'b1;
                        pins_q.out_en_n   <= 1'b1;
                        rsp_valid_q       <= 1'b1;
                        rsp_data_q        <= data_in;
                        prot_q            <= (cur_q.op == OP_PROT_VERIFY) &&
                                             (data_in[7:0] == PROTECTED_CODE[7:0]); // R1
                    end
                S_CLR_LOW:
                    if (timer_done)
                    begin
                        pins_q.clear_n <= 1'b1;
                        cnt_q          <= CNT_W'(READY_CYC); // R12
                    end
                S_CLR_WAIT_RDY:
                    if (state_d == S_CLR_RH)
                        cnt_q <= CNT_W'(RH_CYC); // R13
                S_CLR_RH:
                    // Requester learns commands are accepted again and may reissue
                    if (timer_done)
                        rsp_valid_q <= 1'b1; // R14
                default: ;
            endcase
        end
    end

    chk_read_not_write: assert property (@(posedge ref_clk) disable iff (!resetn)
        !pins_q.out_en_n |-> pins_q.write_en_n && !oe_q) // R3
        else $error("write enable or data drive during read");
    chk_write_oe_high: assert property (@(posedge ref_clk) disable iff (!resetn)
        !pins_q.write_en_n |-> pins_q.out_en_n && !pins_q.chip_sel_n && oe_q) // R6
        else $error("write strobe without proper control levels");
    chk_clear_min_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
        $fell(pins_q.clear_n) && clk_en |-> !pins_q.clear_n [*8]) // R11
        else $error("clear pulse too short");
    chk_no_read_early: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(pins_q.clear_n) |-> pins_q.out_en_n [*5]) // R13
        else $error("read too soon after clear");
    chk_verify_sector: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_q == S_RD && cur_q.op == OP_PROT_VERIFY |->
        pins_q.addr[SECTOR_LSB+SECTOR_W-1:SECTOR_LSB]
            == cur_q.addr[SECTOR_LSB+SECTOR_W-1:SECTOR_LSB]) // R2
        else $error("verify read lost sector address");
    chk_id_mfr_addr: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_q == S_RD && cur_q.op == OP_ID_READ |-> pins_q.addr[1:0] == {1'b0, cur_q.addr[0]}) // R16
        else $error("identification address wrong");
    chk_reset_cmd_data: assert property (@(posedge ref_clk) disable iff (!resetn)
        !pins_q.write_en_n && cur_q.op == OP_RESET_CMD |-> dout_q == RESET_CMD) // R19
        else $error("reset command data wrong");
    chk_id_third_write: assert property (@(posedge ref_clk) disable iff (!resetn)
        !pins_q.write_en_n && cur_q.op == OP_ID_READ && step_q == 3'd2 |->
        dout_q == ID_CMD && pins_q.addr == UNLOCK_ADDR1) // R18
        else $error("identification command write wrong");
endmodule
`default_nettype wire

// >>> flash_model.sv
/*
 * Behavioural flash device on the far side of the host controller pins.
 * Assumes pins change only on ref_clk edges; word mode only.
 */
`timescale 1ns/10ps
`default_nettype none
module flash_model
#(
    parameter logic [15:0] MFR_CODE = 16'h0011, // Arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h0022, // Arbitrary value
    parameter logic [6:0]  LOCKED   = 7'h03,
    parameter int          BUSY_CYC = 40
)
(
    input  wire logic                          ref_clk,
    input  wire flash_host_pkg::pins_t         pins,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_out,
    output logic [flash_host_pkg::DATA_W-1:0]  data_in,
    output logic                               ready_busy_out
);
    import flash_host_pkg::*;
    logic [1:0]  st_q = 2'd0;
    pins_t       prev_q = '1;
    logic [15:0] wd_q = 16'h0000;
    logic [15:0] last_q = 16'h0000;
    int          busy_q = 0;
    logic [1:0]  nxt;
    // Command latched when the first of write enable or chip select rises
    wire wr_end = !prev_q.chip_sel_n && !prev_q.write_en_n && pins.clear_n
        && (pins.write_en_n || pins.chip_sel_n);
    wire rd_on = !pins.chip_sel_n && !pins.out_en_n && pins.clear_n;
    wire [10:0] wa = prev_q.addr[10:0];
    wire [15:0] id_val = (pins.addr[1:0] == 2'd0) ? MFR_CODE :
        (pins.addr[1:0] == 2'd1) ? DEV_CODE :
        {15'h0000, pins.addr[18:12] == LOCKED};
    wire [15:0] rd_val = (st_q == 2'd3) ? id_val : (pins.addr[15:0] ^ 16'h5A5A);
    // Released bus shows a changing pattern so stale data never looks valid
    assign data_in = rd_on ? rd_val : ~last_q;
    assign ready_busy_out = (busy_q == 0);
    always_comb
    begin
        if (wd_q[7:0] == 8'hF0) nxt = 2'd0;
        else if (st_q == 2'd3) nxt = 2'd3;
        else if (st_q == 2'd0 && wa == 11'h555 && wd_q[7:0] == 8'hAA) nxt = 2'd1;
        else if (st_q == 2'd1 && wa == 11'h2AA && wd_q[7:0] == 8'h55) nxt = 2'd2;
        else if (st_q == 2'd2 && wa == 11'h555 && wd_q[7:0] == 8'h90) nxt = 2'd3;
        else nxt = 2'd0;
    end
    always_ff @(posedge ref_clk)
    begin
        prev_q <= pins;
        wd_q   <= data_out;
        last_q <= data_in;
        if (!pins.clear_n)
        begin
            st_q   <= 2'd0;
            busy_q <= BUSY_CYC;
        end
        else
        begin
            if (busy_q > 0) busy_q <= busy_q - 1;
            if (wr_end) st_q <= nxt;
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
/*
 * Self-checking bench for the flash host controller against the flash model.
 * Assumes one request at a time and answers within a few thousand cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
    import flash_host_pkg::*;
    localparam logic [15:0] MFR = 16'h0011;
    localparam logic [15:0] DEV = 16'h0022;
    logic ref_clk = 0, resetn = 0, req_valid = 0, req_ready, rsp_valid, rsp_prot;
    logic ready_busy_out, data_oe;
    logic clk_en = 1;
    req_t req = '0;
    pins_t pins;
    logic [DATA_W-1:0] rsp_data, data_out, data_in;
    int bad_count = 0, num_checks = 0, cyc = 0, low_n = 0, hi_n = 0;

    flash_host_ctrl flash_host_ctrl_inst (.ref_clk(ref_clk), .resetn(resetn),
        .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_protected(rsp_prot),
        .pins(pins), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .ready_busy_out(ready_busy_out));
    flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_model_inst (.ref_clk(ref_clk),
        .pins(pins), .data_out(data_out), .data_in(data_in),
        .ready_busy_out(ready_busy_out));

    initial forever #5 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk({15'h0000, got}, {15'h0000, exp}, m);
    endtask
    task automatic do_op(input op_t op, input logic [18:0] a, input logic [15:0] d);
        int n;
        n = 0;
        chk_bit(req_ready, 1'b1, "idle before request");
        req = '{op, a, d};
        req_valid = 1;
        @(posedge ref_clk);
        #1 req_valid = 0;
        while (rsp_valid !== 1'b1 && n < 3000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk_bit(rsp_valid, 1'b1, "answer");
    endtask
    task automatic rd(input logic [18:0] a, input logic [15:0] exp, input string m);
        do_op(OP_READ, a, 16'h0000);
        chk(rsp_data, exp, m);
    endtask
    task automatic t_array();
        rd(19'h0_1234, 16'h1234 ^ 16'h5A5A, "array");
        rd(19'h7_0555, 16'h0555 ^ 16'h5A5A, "array again");
    endtask
    task automatic t_ident();
        do_op(OP_ID_READ, ID_MFR_ADDR, 16'h0000);
        chk(rsp_data, MFR, "maker code");
        do_op(OP_ID_READ, ID_DEV_ADDR, 16'h0000);
        chk(rsp_data, DEV, "device code");
        rd(ID_MFR_ADDR, MFR, "id held");
        do_op(OP_RESET_CMD, 19'h0_0000, 16'h0000);
        rd(19'h0_0000, 16'h5A5A, "after reset cmd");
    endtask
    task automatic t_verify();
        for (int s = 2; s < 5; s++)
        begin
            do_op(OP_PROT_VERIFY, {s[6:0], 12'h000}, 16'h0000);
            chk(rsp_data, (s == 3) ? 16'h0001 : 16'h0000, "verify");
            chk_bit(rsp_prot, s == 3, "protected flag");
        end
        do_op(OP_RESET_CMD, 19'h0_0000, 16'h0000);
    endtask
    task automatic t_badseq();
        do_op(OP_WRITE, UNLOCK_ADDR1, UNLOCK_DATA1);
        do_op(OP_WRITE, 19'h0_0123, UNLOCK_DATA2);
        // If the bad word were ignored, these two would finish the id sequence
        do_op(OP_WRITE, UNLOCK_ADDR2, UNLOCK_DATA2);
        do_op(OP_WRITE, UNLOCK_ADDR1, ID_CMD);
        rd(19'h0_0000, 16'h5A5A, "bad sequence");
        do_op(OP_WRITE, UNLOCK_ADDR1, UNLOCK_DATA1);
        do_op(OP_RESET_CMD, 19'h0_0333, 16'h0000);
        do_op(OP_WRITE, UNLOCK_ADDR2, UNLOCK_DATA2);
        do_op(OP_WRITE, UNLOCK_ADDR1, ID_CMD);
        rd(19'h0_0000, 16'h5A5A, "reset mid sequence");
    endtask
    task automatic t_clear();
        do_op(OP_ID_READ, ID_MFR_ADDR, 16'h0000);
        do_op(OP_HW_CLEAR, 19'h0_0000, 16'h0000);
        chk_bit(ready_busy_out, 1'b1, "ready after clear");
        rd(19'h0_0000, 16'h5A5A, "array after clear");
        do_op(OP_ID_READ, ID_MFR_ADDR, 16'h0000);
        chk(rsp_data, MFR, "reissued id read");
        do_op(OP_RESET_CMD, 19'h0_0000, 16'h0000);
    endtask
    task automatic t_freeze();
        int n;
        n = 0;
        req = '{OP_READ, 19'h0_0042, 16'h0000};
        req_valid = 1;
        @(posedge ref_clk);
        #1 req_valid = 0;
        clk_en = 0;
        repeat (20) @(posedge ref_clk);
        #1 chk_bit(rsp_valid, 1'b0, "frozen read");
        clk_en = 1;
        while (rsp_valid !== 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk_bit(rsp_valid, 1'b1, "answer after freeze");
        chk(rsp_data, 16'h0042 ^ 16'h5A5A, "data after freeze");
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Pin discipline watched every cycle
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            $display("unexpected at %0t: run too long", $time);
            summarize();
        end
        if (resetn)
        begin
            if (!pins.out_en_n) chk_bit(pins.write_en_n, 1'b1, "read pins");
            if (!pins.write_en_n) chk_bit(pins.out_en_n, 1'b1, "write pins");
            if (!pins.out_en_n) chk_bit(data_oe, 1'b0, "host drive in read");
            if (!pins.write_en_n) chk_bit(data_oe, 1'b1, "host drive in write");
            if (!pins.clear_n) low_n++;
            else if (low_n > 0)
            begin
                chk_bit(low_n >= CLEAR_CYC, 1'b1, "clear pulse");
                low_n = 0;
                hi_n = 1;
            end
            else if (hi_n > 0 && !pins.out_en_n)
            begin
                chk_bit(hi_n >= RH_CYC, 1'b1, "clear to read");
                hi_n = 0;
            end
            else if (hi_n > 0) hi_n++;
        end
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        #1 resetn = 1;
        t_array();
        t_ident();
        t_verify();
        t_badseq();
        t_clear();
        t_freeze();
        summarize();
    end
endmodule
`default_nettype wire
